// ### include/gtr_pkg.sv
// Package: register map, fields and types of the translation request unit
package gtr_pkg;
  localparam logic [11:0] OFF_CTRL    = 12'h100;
  localparam logic [11:0] OFF_SID_LO  = 12'h108;
  localparam logic [11:0] OFF_SID_HI  = 12'h10c;
  localparam logic [11:0] OFF_ADDR_LO = 12'h110;
  localparam logic [11:0] OFF_ADDR_HI = 12'h114;
  localparam logic [11:0] OFF_RES_LO  = 12'h118;
  localparam logic [11:0] OFF_RES_HI  = 12'h11c;
  localparam logic [11:0] OFF_ENABLE  = 12'h120;
  localparam logic [11:0] OFF_VMSEL   = 12'h124;
  localparam logic [11:0] OFF_STATUS  = 12'h128;
  localparam int          SID_WIDTH   = 16;
  localparam int          SUB_WIDTH   = 8;
  localparam logic        GO_RESET    = 1'h0;
  localparam int          GO_BIT      = 0;
  localparam int          SUBV_BIT    = 20;
  localparam int          PRIV_BIT    = 9;
  localparam int          RNW_BIT     = 8;
  localparam int          INSTR_BIT   = 7;
  localparam int          INHIB_BIT   = 6;
  localparam int          FAULT_BIT   = 0;
  localparam int          FCODE_LSB   = 4;
  localparam logic [1:0]  TYPE_RSVD   = 2'h0;
  localparam logic [7:0]  FC_INVALID_REQUEST_ERROR  = 8'h01;
  localparam logic [7:0]  FC_INTERNAL = 8'h02;
  localparam logic [31:0] CAP_PRESENT = 32'h1;

  typedef struct packed {
    logic [31:0] requester_stream_id;
    logic [19:0] subId;
    logic        subValid;
    logic [51:0] inAddr;
    logic [1:0]  stages;
    logic        privileged;
    logic        readNotWrite;
    logic        instrNotData;
    logic        flagUpdateInhibit;
    logic [31:0] vmSel;
  } gtr_req_t;

  typedef struct packed {
    logic        fault;
    logic [7:0]  fault_reason_code;
    logic [54:0] payload;
  } gtr_res_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT  = 4'h4,
    ST_POST  = 4'h8
  } gtr_state_t;
endpackage

// ### logic/gtr_unit.sv
// Register-driven address translation request unit with APB slave
// Function
// - Clear go only after result is posted
// - Writing go zero has no other effect
// - Go bit resets to zero
// - Ignore go set after enable written zero
// - Go high blocks stream, address, selector, control writes
// - Control, stream, address read-only while go high
// - Disable completes only after go clears
// - Aborted request reports internal-error fault
// - Enable rising clears stale go, then completes
// - Stream register holds stream, substream, valid fields
// - Unimplemented identifier bits read as zero
// - Address register carries input address bits 63:12
// - Type field selects translation stages
// - Reserved type yields invalid-request error
// - Bit nine marks privileged access
// - Registers exist only with capability present
// - Same guarding for every request group
// - Read/write bit; instruction bit ignored for writes
// - Inhibit bit blocks flag updates
// - Result bit zero flags fault
//
// Implementation choice: the APB interface to the registers.
module gtr_unit
  import gtr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Translation logic
  output gtr_req_t         xlatReq,
  output logic             xlatValid,
  output logic             xlatAbort,
  output logic             hardware_flag_update,
  input  wire logic        xlatDone,
  input  wire gtr_res_t    xlatRes,
  // Global enable state
  output logic             global_translation_enable
);

  gtr_state_t  state;
  logic        goBit;
  logic        enReq;
  logic        goStale;
  logic [31:0] sidLo;
  logic [31:0] sidHi;
  logic [31:0] addrLo;
  logic [31:0] addrHi;
  logic [31:0] vmSel;
  logic [63:0] result;
  logic        access;
  logic        wr;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        mapped;
  logic        goSetOk;

  // One-cycle wait state per transfer; answer lands on the second access cycle
  assign access = psel & penable & ~pready;
  assign wr     = access & pwrite;
  // Go set accepted only when idle and enable request stays on
  assign goSetOk = wr && paddr == OFF_CTRL && pwdata[GO_BIT] && !goBit && enReq
                   && global_translation_enable;

  // Request registers, ignored while go is high
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sidLo  <= 32'h0;
      sidHi  <= 32'h0;
      addrLo <= 32'h0;
      addrHi <= 32'h0;
      vmSel  <= 32'h0;
    end
    else if (clkEn && wr && !goBit)
    begin
      case (paddr)
        // Unimplemented id bits kept zero
        OFF_SID_LO:  sidLo <= {{(32 - SID_WIDTH){1'b0}}, pwdata[SID_WIDTH-1:0]};
        OFF_SID_HI:  sidHi <= {11'h0, pwdata[SUBV_BIT],
                               {(20 - SUB_WIDTH){1'b0}}, pwdata[SUB_WIDTH-1:0]};
        // Low reserved bits read zero
        OFF_ADDR_LO: addrLo <= {pwdata[31:6], 6'h0};
        OFF_ADDR_HI: addrHi <= pwdata;
        OFF_VMSEL:   vmSel <= pwdata;
        default:     ;
      endcase
    end
  end

  // Global enable request from software
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      enReq <= 1'b0;
    else if (clkEn && wr && paddr == OFF_ENABLE)
      enReq <= pwdata[0];
  end

  // Effective enable; disable waits for go to clear, enable waits for stale go to clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      global_translation_enable <= 1'b0;
    else if (clkEn)
    begin
      if (!enReq && !goBit)
        global_translation_enable <= 1'b0;
      else if (enReq && !goStale)
        global_translation_enable <= 1'b1;
    end
  end

  // Stale go: write of go while disabled clears goStale, so nothing is stored
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      goStale <= 1'b0;
    else if (clkEn)
    begin
      if (enReq && goStale)
        goStale <= 1'b0;
      else if (wr && paddr == OFF_CTRL && pwdata[GO_BIT] && !goBit && !enReq
               && !global_translation_enable)
        goStale <= 1'b0;
    end
  end

  // Go bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      goBit <= GO_RESET;
    else if (clkEn)
    begin
      if (goSetOk)
        goBit <= 1'b1;
      else if (state == ST_POST)
        goBit <= 1'b0;
    end
  end

  // Sequencer: issue, wait, post
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state <= ST_IDLE;
    else if (clkEn)
    begin
      case (state)
        ST_IDLE:  if (goSetOk) state <= ST_ISSUE;
        ST_ISSUE: state <= (xlatReq.stages == TYPE_RSVD) ? ST_POST : ST_WAIT;
        ST_WAIT:  if (xlatDone || !enReq) state <= ST_POST;
        ST_POST:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Request capture and handoff
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      xlatReq              <= '0;
      xlatValid            <= 1'b0;
      xlatAbort            <= 1'b0;
      hardware_flag_update <= 1'b0;
    end
    else if (clkEn)
    begin
      xlatAbort <= 1'b0;
      if (goSetOk)
      begin
        xlatReq.requester_stream_id          <= sidLo;
        xlatReq.subId             <= sidHi[19:0];
        xlatReq.subValid          <= sidHi[SUBV_BIT];
        xlatReq.inAddr            <= {addrHi, addrLo[31:12]};
        xlatReq.stages            <= addrLo[11:10];
        xlatReq.privileged        <= addrLo[PRIV_BIT];
        xlatReq.readNotWrite      <= addrLo[RNW_BIT];
        xlatReq.instrNotData      <= addrLo[RNW_BIT] & addrLo[INSTR_BIT];
        xlatReq.flagUpdateInhibit <= addrLo[INHIB_BIT];
        xlatReq.vmSel             <= vmSel;
      end
      if (state == ST_ISSUE && xlatReq.stages != TYPE_RSVD)
      begin
        xlatValid            <= 1'b1;
        hardware_flag_update <= ~xlatReq.flagUpdateInhibit;
      end
      else if (state == ST_WAIT && (xlatDone || !enReq))
      begin
        xlatValid            <= 1'b0;
        hardware_flag_update <= 1'b0;
        xlatAbort            <= ~xlatDone;
      end
    end
  end

  // Result register, written before go clears
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      result <= 64'h0;
    else if (clkEn)
    begin
      if (state == ST_ISSUE && xlatReq.stages == TYPE_RSVD)
        result <= {52'h0, FC_INVALID_REQUEST_ERROR, 3'h0, 1'b1};
      else if (state == ST_WAIT && xlatDone)
        result <= {4'h0, xlatRes.payload[54:7], xlatRes.fault_reason_code, xlatRes.payload[2:0],
                   xlatRes.fault};
      else if (state == ST_WAIT && !enReq)
        result <= {52'h0, FC_INTERNAL, 3'h0, 1'b1};
    end
  end

  // Read decode; all groups present as capability is built
  always_comb
  begin
    mapped      = 1'b1;
    next_prdata = 32'h0;
    case (paddr)
      OFF_CTRL:    next_prdata = {31'h0, goBit | goStale};
      OFF_SID_LO:  next_prdata = sidLo;
      OFF_SID_HI:  next_prdata = sidHi;
      OFF_ADDR_LO: next_prdata = addrLo;
      OFF_ADDR_HI: next_prdata = addrHi;
      OFF_RES_LO:  next_prdata = result[31:0];
      OFF_RES_HI:  next_prdata = result[63:32];
      OFF_ENABLE:  next_prdata = {31'h0, enReq};
      OFF_VMSEL:   next_prdata = vmSel;
      OFF_STATUS:  next_prdata = {30'h0, global_translation_enable, CAP_PRESENT[0]};
      default:     mapped = 1'b0;
    endcase
  end

  assign next_pready = access;

  // APB answer
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      pready  <= next_pready;
      prdata  <= (access && !pwrite) ? next_prdata : 32'h0;
      pslverr <= access & ~mapped;
    end
  end

endmodule

// ### bench/gtr_unit_properties.sv
// Checker: port-level properties of the translation request unit
module gtr_unit_properties
  import gtr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire gtr_req_t    xlatReq,
  input wire logic        xlatValid,
  input wire logic        xlatAbort,
  input wire logic        hardware_flag_update,
  input wire logic        xlatDone,
  input wire gtr_res_t    xlatRes,
  input wire logic        global_translation_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_access;
    psel && penable && !pready && clkEn;
  endsequence
  sequence s_finish;
    xlatValid && xlatDone && clkEn;
  endsequence
  chk_reset_quiet: assert property ($past(!rst_b) |-> !xlatValid && !pready)
    else $error("outputs active after reset");
  chk_ready_wait: assert property (s_access |=> pready ##1 !pready)
    else $error("access not answered in one wait state");
  chk_error_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  chk_done_drop: assert property (s_finish |=> !xlatValid)
    else $error("request held after done");
  chk_abort_drop: assert property (xlatAbort |=> !xlatValid && !xlatAbort)
    else $error("abort not a single pulse ending the request");
  chk_req_hold: assert property (xlatValid |=> $stable(xlatReq))
    else $error("request changed while running");
  chk_flag_inhibit: assert property (xlatValid |-> hardware_flag_update == !xlatReq.flagUpdateInhibit)
    else $error("flag update against inhibit bit");
  chk_enable_fall: assert property ($fell(global_translation_enable) |-> !xlatValid)
    else $error("enable dropped while request running");
endmodule

// ### bench/gtr_unit_bench.sv
// Bench: self-checking testbench of the translation request unit
module gtr_unit_bench
  import gtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] x;
  } gtr_row_t;
  localparam gtr_row_t ROWS [6] = '{
    '{OFF_ENABLE, 1'h1, 32'h1, 32'h1}, '{OFF_STATUS, 1'h0, 32'h0, 32'h3},
    '{OFF_SID_LO, 1'h1, 32'hffffffff, 32'h0000ffff},
    '{OFF_SID_HI, 1'h1, 32'hffffffff, 32'h001000ff},
    '{OFF_ADDR_LO, 1'h1, 32'h12345fff, 32'h12345fc0},
    '{OFF_ADDR_HI, 1'h1, 32'hdeadbeef, 32'hdeadbeef}};
  logic        core_clk, rst_b, clkEn, psel, penable, pwrite, pready, pslverr, er;
  logic        xlatValid, xlatAbort, hardware_flag_update, xlatDone;
  logic        global_translation_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gtr_req_t    xlatReq;
  gtr_res_t    xlatRes;
  int          errTotal, testsRun;
  gtr_unit dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xlatReq(xlatReq), .xlatValid(xlatValid),
    .xlatAbort(xlatAbort), .hardware_flag_update(hardware_flag_update),
    .xlatDone(xlatDone), .xlatRes(xlatRes),
    .global_translation_enable(global_translation_enable));
  task automatic conclude;
    if (errTotal == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    testsRun++;
    if (g !== x)
    begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer, held until pready is sampled high or 20 access cycles pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    repeat (20)
    begin
      @(posedge core_clk);
      if (pready === 1'h1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(rd, x);
  endtask
  task automatic waitIdle;
    repeat (20)
    begin
      apb(1'h0, OFF_CTRL, 32'h0);
      if (rd[0] === 1'h0)
        break;
    end
  endtask
  task automatic waitValid;
    repeat (10)
      if (xlatValid !== 1'h1)
        @(posedge core_clk);
  endtask
  task automatic complete(input gtr_res_t r);
    @(posedge core_clk);
    xlatDone <= 1'h1;
    xlatRes  <= r;
    @(posedge core_clk);
    xlatDone <= 1'h0;
    waitIdle();
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    errTotal++;
    conclude();
  end
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, xlatDone, xlatRes} = '0;
    clkEn = 1'h1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'h1;
    foreach (ROWS[i])
    begin
      if (ROWS[i].w)
        apb(1'h1, ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].x);
    end
    apb(1'h1, 12'h0fc, 32'h5);
    rdchk(12'h0fc, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'h1, OFF_SID_LO, 32'h12);
    apb(1'h1, OFF_ADDR_LO, 32'h56c0);
    apb(1'h1, OFF_ADDR_HI, 32'h1);
    apb(1'h1, OFF_CTRL, 32'h1);
    waitValid();
    chk(xlatReq.requester_stream_id, 32'h12);
    chk(xlatReq.inAddr[51:20], 32'h1);
    chk(32'(xlatReq.inAddr[19:0]), 32'h5);
    chk(32'({xlatReq.stages, xlatReq.privileged, xlatReq.readNotWrite, xlatReq.instrNotData,
      xlatReq.flagUpdateInhibit, hardware_flag_update}), 32'h32);
    apb(1'h1, OFF_SID_LO, 32'h77);
    rdchk(OFF_SID_LO, 32'h12);
    apb(1'h1, OFF_ADDR_LO, 32'h0);
    rdchk(OFF_ADDR_LO, 32'h56c0);
    rdchk(OFF_CTRL, 32'h1);
    complete('{fault: 1'h0, fault_reason_code: 8'h0, payload: 55'h1});
    apb(1'h0, OFF_RES_LO, 32'h0);
    chk(32'(rd[0]), 32'h0);
    apb(1'h1, OFF_ADDR_LO, 32'h0);
    apb(1'h1, OFF_CTRL, 32'h1);
    waitIdle();
    apb(1'h0, OFF_RES_LO, 32'h0);
    chk(32'(rd[11:0]), 32'h011);
    apb(1'h1, OFF_ADDR_LO, 32'h5400);
    apb(1'h1, OFF_CTRL, 32'h1);
    waitValid();
    chk(32'(hardware_flag_update), 32'h1);
    apb(1'h1, OFF_ENABLE, 32'h0);
    waitIdle();
    apb(1'h0, OFF_RES_LO, 32'h0);
    chk(32'(rd[11:0]), 32'h021);
    rdchk(OFF_STATUS, 32'h1);
    apb(1'h1, OFF_CTRL, 32'h1);
    rdchk(OFF_CTRL, 32'h0);
    apb(1'h1, OFF_ENABLE, 32'h1);
    rdchk(OFF_CTRL, 32'h0);
    apb(1'h1, OFF_CTRL, 32'h0);
    chk(32'(xlatValid), 32'h0);
    apb(1'h1, OFF_CTRL, 32'h1);
    waitValid();
    rst_b <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    rdchk(OFF_CTRL, 32'h0);
    conclude();
  end
endmodule
bind gtr_unit gtr_unit_properties u_props (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .xlatReq(xlatReq),
  .xlatValid(xlatValid), .xlatAbort(xlatAbort), .hardware_flag_update(hardware_flag_update),
  .xlatDone(xlatDone), .xlatRes(xlatRes), .global_translation_enable(global_translation_enable));
